// ===== rtl/conv_ctrl_reg.sv
// converter control register store and field decode
`timescale 1ns/1ns
module conv_ctrl_reg
  import conv_ctrl_pkg::*;
#(
  parameter int CONV_LEN = CONV_CYCLES,
  parameter int STEP_LEN = STEP_CYCLES
)(
  input wire logic SYS_CLK_I,
  input wire logic RST_N_I,
  input wire logic CAL_N_I,
  input wire logic WR_I,
  input wire logic WORD_MODE_I,
  input wire logic HIGH_BYTE_I,
  input wire logic [15:0] DATA_I,
  input wire logic SLEEP_N_I,
  output logic [13:0] STATUS_FIELDS_O,
  output logic SINGLE_ENDED_O,
  output logic [2:0] INPUT_PICK_O,
  output logic [3:0] POS_SRC_O,
  output logic [3:0] NEG_SRC_O,
  output logic BIPOLAR_O,
  output logic [1:0] POWER_SAVE_O,
  output logic POWER_SLEEP_O,
  output logic [1:0] READ_TARGET_O,
  output logic [3:0] READ_ONEHOT_O,
  output logic CAL_FAMILY_O,
  output logic [2:0] CAL_TYPE_O,
  output logic [1:0] COEF_ADDR_O,
  output logic [1:0] CAL_STEP_O,
  output logic TEST_WR_O,
  output logic CAL_WR_O,
  output logic [13:0] WR_DATA_O,
  output logic BUSY_O
);
  logic [13:0] ctrl_reg;
  logic [7:0] low_byte_reg;
  logic [13:0] ctrl_next;
  logic busy_reg;
  logic test_wr_reg;
  logic cal_wr_reg;
  logic [13:0] wr_data_reg;
  logic [3:0] pos_reg;
  logic [3:0] neg_reg;
  logic bip_reg;
  logic sleep_reg;
  logic [3:0] rd_oh_reg;
  logic [2:0] cal_type_reg;
  logic [1:0] coef_reg;
  logic op_busy;
  logic op_done;
  logic [1:0] op_step;

  //////////////////////////////////////////////////////////////////////
  // word assembly
  // rst pin low clears all logic, cal pin low clears all but the write pulses and write data
  wire logic rst_all_n = RST_N_I;
  wire logic byte_low = WR_I && !WORD_MODE_I && !HIGH_BYTE_I;
  wire logic word_done = WR_I && (WORD_MODE_I || HIGH_BYTE_I);
  wire logic [15:0] word = WORD_MODE_I ? DATA_I :
    {DATA_I[7:0], low_byte_reg};
  wire logic [1:0] target = word[TGT_HI:TGT_LO];
  wire logic ctrl_hit = word_done && (target == TGT_CTRL) && CAL_N_I;
  wire logic [13:0] payload = word[CTRL_W-1:0];

  //////////////////////////////////////////////////////////////////////
  // field decode of the newly applied value
  wire logic new_sgl = ctrl_next[B_SGL];
  wire logic [2:0] new_ch = ctrl_next[B_CH_HI:B_CH_LO];
  wire logic new_rng = ctrl_next[B_RANGE];
  wire logic [3:0] pair_pos = {1'b0, new_ch[1:0], 1'b0} + SRC_IN1;
  wire logic [3:0] se_pos = {1'b0, new_ch[1:0], new_ch[2]} + SRC_IN1;
  // differential code zero gives one and two
  wire logic [3:0] pos_dec = new_sgl ? se_pos : pair_pos;
  wire logic [3:0] neg_dec = new_sgl ? (new_rng ? SRC_IN8 : SRC_GND) :
    (pair_pos + 4'h1);
  wire logic bip_dec = !new_sgl && new_rng;
  wire logic [1:0] new_rd = ctrl_next[B_RD_HI:B_RD_LO];
  wire logic [3:0] rd_dec = {new_rd == RD_STATUS, new_rd == RD_CAL,
    new_rd == RD_TEST, new_rd == RD_RESULT};
  wire logic [2:0] type_dec = {ctrl_next[B_CALFAM],
    ctrl_next[B_CALSUB_HI:B_CALSUB_LO]};
  wire logic cal_go = ctrl_hit && payload[B_CALGO] && !op_busy;
  wire logic conv_go = ctrl_hit && payload[B_CONV] && !op_busy;

  //////////////////////////////////////////////////////////////////////
  always_comb
  begin
    ctrl_next = ctrl_reg;
    if (ctrl_hit)
      ctrl_next = payload;
    if (op_done && !ctrl_hit)
      ctrl_next[B_CONV] = 1'b0;
    // launch is an action, not kept
    if (op_done && !ctrl_hit)
      ctrl_next[B_CALGO] = 1'b0;
    // cal pin low clears decoded fields in step with the register
    if (!CAL_N_I)
      ctrl_next = CTRL_RESET;
  end

  always_ff @(posedge SYS_CLK_I or negedge rst_all_n)
  begin
    if (!rst_all_n)
    begin
      ctrl_reg <= CTRL_RESET;
      low_byte_reg <= 8'h00;
    end
    else if (!CAL_N_I)
    begin
      ctrl_reg <= CTRL_RESET;
      low_byte_reg <= 8'h00;
    end
    else
    begin
      ctrl_reg <= ctrl_next;
      if (byte_low)
        low_byte_reg <= DATA_I[7:0];
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge rst_all_n)
  begin
    if (!rst_all_n)
    begin
      pos_reg <= SRC_IN1;
      neg_reg <= SRC_IN1 + 4'h1;
      bip_reg <= 1'b0;
      rd_oh_reg <= 4'h1;
      cal_type_reg <= 3'h0;
      coef_reg <= 2'h0;
      sleep_reg <= 1'b0;
    end
    else
    begin
      pos_reg <= pos_dec;
      neg_reg <= neg_dec;
      bip_reg <= bip_dec;
      rd_oh_reg <= rd_dec;
      cal_type_reg <= type_dec;
      if (!ctrl_next[B_CALGO])
        coef_reg <= ctrl_next[B_CALSUB_HI:B_CALSUB_LO];
      sleep_reg <= !SLEEP_N_I && (ctrl_next[B_PWR_HI:B_PWR_LO] != 2'h0);
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge rst_all_n)
  begin
    if (!rst_all_n)
    begin
      test_wr_reg <= 1'b0;
      cal_wr_reg <= 1'b0;
      wr_data_reg <= 14'h0000;
      busy_reg <= 1'b0;
    end
    else
    begin
      test_wr_reg <= word_done && (target == TGT_TEST);
      cal_wr_reg <= word_done && (target == TGT_CAL);
      if (word_done)
        wr_data_reg <= payload;
      busy_reg <= (op_busy && !op_done) || cal_go || conv_go;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // calibration step sequencing
  conv_op_timer #(
    .CONV_LEN(CONV_LEN),
    .STEP_LEN(STEP_LEN)
  ) u_timer (
    .clk_i(SYS_CLK_I),
    .rst_n_i(rst_all_n && CAL_N_I),
    .start_conv_i(conv_go),
    .start_cal_i(cal_go),
    .cal_sub_i(payload[B_CALSUB_HI:B_CALSUB_LO]),
    .busy_o(op_busy),
    .done_o(op_done),
    .step_o(op_step)
  );

  // no read path, status copy only
  assign STATUS_FIELDS_O = ctrl_reg;
  assign SINGLE_ENDED_O = ctrl_reg[B_SGL];
  assign INPUT_PICK_O = ctrl_reg[B_CH_HI:B_CH_LO];
  assign POS_SRC_O = pos_reg;
  assign NEG_SRC_O = neg_reg;
  assign BIPOLAR_O = bip_reg;
  assign POWER_SAVE_O = ctrl_reg[B_PWR_HI:B_PWR_LO];
  assign POWER_SLEEP_O = sleep_reg;
  assign READ_TARGET_O = ctrl_reg[B_RD_HI:B_RD_LO];
  assign READ_ONEHOT_O = rd_oh_reg;
  assign CAL_FAMILY_O = ctrl_reg[B_CALFAM];
  assign CAL_TYPE_O = cal_type_reg;
  assign COEF_ADDR_O = coef_reg;
  assign CAL_STEP_O = op_step;
  assign TEST_WR_O = test_wr_reg;
  assign CAL_WR_O = cal_wr_reg;
  assign WR_DATA_O = wr_data_reg;
  assign BUSY_O = busy_reg;
endmodule

// ===== rtl/conv_op_timer.sv
// operation sequencer: conversion or multi-step calibration timing
`timescale 1ns/1ns
module conv_op_timer
  import conv_ctrl_pkg::*;
#(
  parameter int CONV_LEN = CONV_CYCLES,
  parameter int STEP_LEN = STEP_CYCLES
)(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic start_conv_i,
  input wire logic start_cal_i,
  input wire logic [1:0] cal_sub_i,
  output logic busy_o,
  output logic done_o,
  output logic [1:0] step_o
);
  typedef enum logic [1:0] {IDLE, CONV, CAL} op_t;
  op_t state_reg;
  logic [15:0] cnt_reg;
  logic [1:0] step_reg;
  logic [1:0] last_step_reg;
  wire logic cnt_end = (cnt_reg == 16'h0000);
  wire logic [15:0] conv_load = 16'(CONV_LEN - 1);
  wire logic [15:0] step_load = 16'(STEP_LEN - 1);
  // first step and final step of each calibration kind
  wire logic [1:0] first_step =
    (cal_sub_i == 2'h0) ? STEP_DAC :
    (cal_sub_i == 2'h2) ? STEP_OFFS : STEP_GAIN;
  wire logic [1:0] last_step =
    (cal_sub_i == 2'h3) ? STEP_GAIN : STEP_OFFS;

  assign busy_o = (state_reg != IDLE);
  assign step_o = step_reg;
  assign done_o = busy_o && cnt_end &&
    ((state_reg == CONV) || (step_reg == last_step_reg));

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_reg <= IDLE;
      cnt_reg <= 16'h0000;
      step_reg <= STEP_DONE;
      last_step_reg <= STEP_DONE;
    end
    else
    begin
      case (state_reg)
        IDLE:
        begin
          // calibration takes precedence over a conversion start
          if (start_cal_i)
          begin
            state_reg <= CAL;
            cnt_reg <= step_load;
            step_reg <= first_step;
            last_step_reg <= last_step;
          end
          else if (start_conv_i)
          begin
            state_reg <= CONV;
            cnt_reg <= conv_load;
          end
        end
        CONV:
        begin
          if (cnt_end)
            state_reg <= IDLE;
          else
            cnt_reg <= cnt_reg - 16'h0001;
        end
        CAL:
        begin
          if (!cnt_end)
            cnt_reg <= cnt_reg - 16'h0001;
          else if (step_reg == last_step_reg)
          begin
            // step output reads as done straight from the flop
            state_reg <= IDLE;
            step_reg <= STEP_DONE;
          end
          else
          begin
            // dac, then gain, then offset
            step_reg <= step_reg + 2'h1;
            cnt_reg <= step_load;
          end
        end
        default:
          state_reg <= IDLE;
      endcase
    end
  end
endmodule

// ===== shared/conv_ctrl_pkg.sv
// shared constants for the converter control register block
package conv_ctrl_pkg;
  localparam int WORD_W = 16;
  localparam int CTRL_W = 14;
  localparam logic [13:0] CTRL_RESET = 14'h0000;
  // write-target field of the 16-bit word
  localparam int TGT_HI = 15;
  localparam int TGT_LO = 14;
  localparam logic [1:0] TGT_NONE = 2'h0;
  localparam logic [1:0] TGT_TEST = 2'h1;
  localparam logic [1:0] TGT_CAL = 2'h2;
  localparam logic [1:0] TGT_CTRL = 2'h3;
  // control field positions
  localparam int B_SGL = 13;
  localparam int B_CH_HI = 12;
  localparam int B_CH_LO = 10;
  localparam int B_PWR_HI = 9;
  localparam int B_PWR_LO = 8;
  localparam int B_RD_HI = 7;
  localparam int B_RD_LO = 6;
  localparam int B_RANGE = 5;
  localparam int B_CONV = 4;
  localparam int B_CALFAM = 3;
  localparam int B_CALSUB_HI = 2;
  localparam int B_CALSUB_LO = 1;
  localparam int B_CALGO = 0;
  // read target codes
  localparam logic [1:0] RD_RESULT = 2'h0;
  localparam logic [1:0] RD_TEST = 2'h1;
  localparam logic [1:0] RD_CAL = 2'h2;
  localparam logic [1:0] RD_STATUS = 2'h3;
  // input selects: 1..8 are analog inputs, 0 is analog ground
  localparam logic [3:0] SRC_GND = 4'h0;
  localparam logic [3:0] SRC_IN1 = 4'h1;
  localparam logic [3:0] SRC_IN8 = 4'h8;
  // calibration step codes
  localparam logic [1:0] STEP_DAC = 2'h0;
  localparam logic [1:0] STEP_GAIN = 2'h1;
  localparam logic [1:0] STEP_OFFS = 2'h2;
  localparam logic [1:0] STEP_DONE = 2'h3;
  // default operation lengths in clock cycles
  localparam int CONV_CYCLES = 18;
  localparam int STEP_CYCLES = 64;
endpackage

// ===== tb/adc_control_register_decode_tb.sv
// self-checking bench for the converter control register
`timescale 1ns/1ns
module adc_control_register_decode_tb;
  import conv_ctrl_pkg::*;
  logic SYS_CLK_I = 1'b0;
  logic RST_N_I = 1'b0;
  logic CAL_N_I = 1'b1;
  logic SLEEP_N_I = 1'b1;
  logic WR_I, WORD_MODE_I, HIGH_BYTE_I;
  logic [15:0] DATA_I;
  logic [13:0] STATUS_FIELDS_O, WR_DATA_O;
  logic [3:0] POS_SRC_O, NEG_SRC_O, READ_ONEHOT_O;
  logic [2:0] INPUT_PICK_O, CAL_TYPE_O;
  logic [1:0] POWER_SAVE_O, READ_TARGET_O, COEF_ADDR_O, CAL_STEP_O;
  logic SINGLE_ENDED_O, BIPOLAR_O, POWER_SLEEP_O, CAL_FAMILY_O;
  logic TEST_WR_O, CAL_WR_O, BUSY_O;
  logic [31:0] notes[$];
  logic [2:0] pipe = 3'h0;
  logic [13:0] mc;
  logic [15:0] r = 16'h004A;
  int bad_count = 0;
  int num_checks = 0;
  int cycles = 0;
  localparam int CONV_T = 4;
  localparam int STEP_T = 4;
  logic [31:0] wr_want = 32'h0;
  logic [1:0] want_step = STEP_DONE;
  wire [31:0] wr_seen = {16'h0, CAL_WR_O, TEST_WR_O, WR_DATA_O};
  wire [31:0] fields = {21'h0, SINGLE_ENDED_O, INPUT_PICK_O, POWER_SAVE_O,
    READ_TARGET_O, CAL_FAMILY_O, CAL_STEP_O};
  wire [31:0] seen = {STATUS_FIELDS_O, POS_SRC_O, NEG_SRC_O, BIPOLAR_O,
    READ_ONEHOT_O, CAL_TYPE_O, POWER_SLEEP_O, BUSY_O};
  always #10 SYS_CLK_I = ~SYS_CLK_I;
  conv_ctrl_reg #(.CONV_LEN(CONV_T), .STEP_LEN(STEP_T)) uut (.*);
  host_model host (.clk_i(SYS_CLK_I), .wr_o(WR_I), .word_mode_o(WORD_MODE_I),
    .high_byte_o(HIGH_BYTE_I), .data_o(DATA_I));
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // single-ended inputs 2,4,6,8 sit on the upper half of the pick code
  function automatic logic [31:0] expect_of(input logic [13:0] c);
    logic [3:0] p;
    logic [3:0] n;
    p = {1'b0, c[11:10], 1'b0} + 4'h1 + {3'h0, c[13] & c[12]};
    n = c[13] ? (c[5] ? SRC_IN8 : SRC_GND) : p + 4'h1;
    return {c, p, n, ~c[13] & c[5], 4'h1 << c[7:6], c[3:1],
      ~SLEEP_N_I & |c[9:8], c[4] | c[0]};
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] want);
    num_checks++;
    if (got !== want)
    begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, got, want);
    end
  endtask
  task report_and_stop;
    $display("checks %0d, mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic idle(output int n);
    for (n = 0; n < 200 && BUSY_O !== 1'b0; n++)
      @(negedge SYS_CLK_I);
  endtask
  task automatic send(input logic [15:0] w, input logic word);
    int n;
    int len;
    logic go;
    logic [31:0] want_f;
    go = (w[15:14] == TGT_CTRL) && w[B_CALGO];
    if (w[15:14] == TGT_CTRL)
      mc = w[13:0];
    wr_want = {16'h0, w[15:14] == TGT_CAL, w[15:14] == TGT_TEST, w[13:0]};
    // first step and length of each calibration kind
    want_step = !go ? STEP_DONE : (w[2:1] == 2'h0) ? STEP_DAC :
      (w[2:1] == 2'h2) ? STEP_OFFS : STEP_GAIN;
    len = !go ? 0 : (w[2:1] == 2'h0) ? 3 * STEP_T :
      (w[2:1] == 2'h1) ? 2 * STEP_T : STEP_T;
    if (!go && w[15:14] == TGT_CTRL && w[B_CONV])
      len = CONV_T;
    notes.push_back(expect_of(mc));
    host.put(w, word);
    repeat (3) @(negedge SYS_CLK_I);
    idle(n);
    mc[B_CONV] = 1'b0;
    mc[B_CALGO] = 1'b0;
    want_f = {21'h0, mc[B_SGL], mc[B_CH_HI:B_CH_LO], mc[B_PWR_HI:B_PWR_LO],
      mc[B_RD_HI:B_RD_LO], mc[B_CALFAM], STEP_DONE};
    check(n, (len > 3) ? len - 3 : 0);
    check({18'h0, STATUS_FIELDS_O}, {18'h0, mc});
    check(fields, want_f);
    if (w[15:14] == TGT_CTRL && !w[0])
      check({30'h0, COEF_ADDR_O}, {30'h0, w[2:1]});
  endtask
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge SYS_CLK_I)
    pipe <= {pipe[1:0], WR_I & (WORD_MODE_I | HIGH_BYTE_I)};
  always @(negedge SYS_CLK_I)
  begin
    if (pipe[0])
      check(wr_seen, wr_want);
    if (pipe[2] && notes.size() > 0)
    begin
      check(seen, notes.pop_front());
      check({30'h0, CAL_STEP_O}, {30'h0, want_step});
    end
  end
  always @(posedge SYS_CLK_I)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      bad_count++;
      report_and_stop();
    end
  end
  initial
  begin
    int i;
    int n;
    mc = CTRL_RESET;
    repeat (6) @(posedge SYS_CLK_I);
    @(negedge SYS_CLK_I);
    RST_N_I = 1'b1;
    check(seen, expect_of(CTRL_RESET));
    for (i = 0; i < 4; i++)
      send({2'h3, 6'h0, i[1:0], 6'h0}, 1'b1);
    for (i = 0; i < 32; i++)
      send({2'h3, i[4], i[3] & i[4], i[2:1], 4'h0, i[0], 5'h0}, 1'b1);
    for (i = 0; i < 8; i++)
      send({2'h3, 10'h0, i[2:0], 1'b1}, 1'b1);
    send(16'hC010, 1'b1);
    // random words, 18 of the 24 byte-wide
    for (i = 0; i < 24; i++)
    begin
      r = lfsr(r);
      SLEEP_N_I = r[15];
      send({2'h3, r[13], r[12] & r[13], r[11:0]}, r[14]);
    end
    for (i = 0; i < 3; i++)
      send({i[1:0], 14'h3FFF}, 1'b1);
    CAL_N_I = 1'b0;
    @(negedge SYS_CLK_I);
    check(seen, expect_of(CTRL_RESET));
    CAL_N_I = 1'b1;
    idle(n);
    mc = CTRL_RESET;
    send(16'hC2A5, 1'b0);
    report_and_stop();
  end
endmodule

// ===== tb/conv_ctrl_reg_properties.sv
// port assertions for the converter control register
`timescale 1ns/1ns
module conv_ctrl_checker
  import conv_ctrl_pkg::*;
(
  input wire logic SYS_CLK_I,
  input wire logic RST_N_I,
  input wire logic CAL_N_I,
  input wire logic WR_I,
  input wire logic WORD_MODE_I,
  input wire logic HIGH_BYTE_I,
  input wire logic [15:0] DATA_I,
  input wire logic [13:0] STATUS_FIELDS_O,
  input wire logic BIPOLAR_O,
  input wire logic [3:0] READ_ONEHOT_O,
  input wire logic [1:0] CAL_STEP_O,
  input wire logic TEST_WR_O,
  input wire logic [13:0] WR_DATA_O,
  input wire logic BUSY_O
);
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (!RST_N_I);
  wire wr_word = WR_I && WORD_MODE_I && CAL_N_I;
  wire wr_ctrl = wr_word && DATA_I[15:14] == TGT_CTRL;
  chk_reset_clear:
    assert property ($rose(RST_N_I) |-> STATUS_FIELDS_O == CTRL_RESET)
    else $error("control not clear after reset");
  chk_word_store:
    assert property (wr_ctrl |=> STATUS_FIELDS_O == $past(DATA_I[13:0]))
    else $error("control word not stored");
  chk_other_target:
    assert property (wr_word && DATA_I[15:14] != TGT_CTRL && !BUSY_O
      |=> $stable(STATUS_FIELDS_O))
    else $error("control changed by other target");
  chk_low_byte_wait:
    assert property (WR_I && !WORD_MODE_I && !HIGH_BYTE_I && CAL_N_I
      && !BUSY_O |=> $stable(STATUS_FIELDS_O))
    else $error("control changed by low byte");
  chk_busy_start:
    assert property (wr_ctrl && !BUSY_O && (DATA_I[4] || DATA_I[0])
      |=> BUSY_O)
    else $error("busy did not rise");
  chk_start_clears:
    assert property ($fell(BUSY_O) && !$past(WR_I)
      |-> STATUS_FIELDS_O[4] == 1'b0 && STATUS_FIELDS_O[0] == 1'b0)
    else $error("start bits left set after operation");
  chk_read_onehot:
    assert property (READ_ONEHOT_O == 4'h1 << STATUS_FIELDS_O[7:6])
    else $error("read select decode wrong");
  chk_range_mode:
    assert property (BIPOLAR_O == (!STATUS_FIELDS_O[13] && STATUS_FIELDS_O[5]))
    else $error("range decode wrong");
  chk_test_pulse:
    assert property (wr_word && DATA_I[15:14] == TGT_TEST
      |=> TEST_WR_O && WR_DATA_O == $past(DATA_I[13:0]))
    else $error("test write not passed on");
  chk_dac_gain:
    assert property (CAL_N_I && $past(CAL_N_I) && $past(CAL_STEP_O) ==
      STEP_DAC && CAL_STEP_O != STEP_DAC |-> CAL_STEP_O == STEP_GAIN)
    else $error("gain step does not follow dac step");
  cov_byte: cover property (WR_I && !WORD_MODE_I && HIGH_BYTE_I);
  cov_dac: cover property (CAL_STEP_O == STEP_DAC);
  cov_conv: cover property (wr_ctrl && DATA_I[4]);
endmodule
bind conv_ctrl_reg conv_ctrl_checker chk_i (.SYS_CLK_I, .RST_N_I, .CAL_N_I,
  .WR_I, .WORD_MODE_I, .HIGH_BYTE_I, .DATA_I, .STATUS_FIELDS_O, .BIPOLAR_O,
  .READ_ONEHOT_O, .CAL_STEP_O, .TEST_WR_O, .WR_DATA_O, .BUSY_O);

// ===== tb/host_model.sv
// host processor model on the parallel write port
`timescale 1ns/1ns
module host_model (
  input wire logic clk_i,
  output logic wr_o,
  output logic word_mode_o,
  output logic high_byte_o,
  output logic [15:0] data_o
);
  initial
  begin
    wr_o = 1'b0;
    word_mode_o = 1'b1;
    high_byte_o = 1'b0;
    data_o = 16'hA5A5;
  end
  // whole word or low then high byte, target in top two bits
  task automatic put(input logic [15:0] w, input logic word);
    @(negedge clk_i);
    wr_o = 1'b1;
    word_mode_o = word;
    high_byte_o = 1'b0;
    data_o = word ? w : {~w[15:8], w[7:0]};
    if (!word)
    begin
      @(negedge clk_i);
      high_byte_o = 1'b1;
      data_o = {~w[7:0], w[15:8]};
    end
    @(negedge clk_i);
    wr_o = 1'b0;
    // released bus must not keep a stale value
    data_o = ~data_o;
  endtask
endmodule
